// ---- dv/t8w_load.sv ----
// Behavioural load on the waveform pin with a weak pull-down.
`timescale 1ns/100ps
module t8w_load (
  input  wire logic pin_o,
  input  wire logic pin_oe,
  output wire logic level
);
  // A released pin sinks to the pull-down level instead of keeping its last value.
  assign level = pin_oe ? pin_o : 1'b0;
endmodule

// ---- dv/t8w_props.sv ----
// Concurrent checks on the ports of the timer waveform block.
`timescale 1ns/100ps
`include "t8w_consts.vh"
module t8w_props (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        irq_ack_ovf,
  input wire logic        irq_ack_cmp,
  input wire logic        overflow_flag,
  input wire logic        compare_match_flag,
  input wire logic        wave_pin_oe
);
  // All checks share the core clock; all but a_reset_quiet are quiet while reset is low.
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // A write answer rises one edge after the later beat is taken, so look two edges back.
  a_write_cause: assert property ($rose(s_axi_bvalid) |->
    $past(s_axi_wvalid && s_axi_wready || s_axi_awvalid && s_axi_awready, 2))
    else $error("write answer without a taken beat");
  // A read answer only follows a taken read address.
  a_read_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
    else $error("read answer without a taken address");
  // A taken read address is answered at the very next edge.
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read address taken without an answer");
  // Words past the last register answer with an error and zero data.
  a_unmapped_read: assert property ($rose(s_axi_rvalid) && $past(s_axi_araddr) > 8'h13 |->
    s_axi_rresp == `T8W_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  // Reset must be seen even while it is asserted, so this one is never disabled.
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> !overflow_flag &&
    !compare_match_flag && !wave_pin_oe && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs not cleared by reset");
  // The compare flag only drops on an acknowledge or a register write.
  a_cmp_sticky: assert property (compare_match_flag && !irq_ack_cmp && !s_axi_wvalid &&
    !$past(s_axi_wvalid) |=> compare_match_flag)
    else $error("compare flag lost without a clear");
  // The overflow flag behaves as a sticky ninth bit.
  a_ovf_sticky: assert property (overflow_flag && !irq_ack_ovf && !s_axi_wvalid &&
    !$past(s_axi_wvalid) |=> overflow_flag)
    else $error("overflow flag lost without a clear");
  // The pin enable follows the direction bit, so it only moves after a write.
  a_oe_by_write: assert property ($changed(wave_pin_oe) |->
    s_axi_bvalid || $past(s_axi_bvalid))
    else $error("pin enable changed without a write");
endmodule

// ---- dv/tb_top.sv ----
// Self-checking bench for the timer waveform block.
`timescale 1ns/100ps
`include "t8w_consts.vh"
module tb_top;
  logic        core_clk = 0;
  logic        rst_n = 0;
  logic        awv = 0, wv = 0, br = 0, arv = 0, rr = 0, ack_o = 0, ack_c = 0;
  logic [7:0]  awa = 0, ara = 0;
  logic [31:0] wd = 0;
  wire         awr, wrdy, bv, arr, rv, ovf, cmpf, pin_o, pin_oe, lvl;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  int          num_errors = 0, checks_done = 0, per, hi, i;
  // Mode, action, compare, clock select, then period and high time in core clocks.
  int          tab [21][6] = '{'{0,1,0,1,512,256}, '{0,3,5,1,0,2500}, '{0,2,5,1,0,0},
    '{2,1,9,1,20,10}, '{3,2,63,1,256,64}, '{3,3,63,1,256,192},
    '{3,2,0,1,256,1}, '{3,2,255,1,0,2500}, '{3,1,0,1,512,256}, '{1,2,100,1,510,200},
    '{1,3,100,1,510,310}, '{1,2,0,1,0,0}, '{1,2,255,1,0,2500}, '{1,3,0,1,0,2500},
    '{2,1,0,1,2,1}, '{2,1,0,2,16,8}, '{2,1,0,3,64,32}, '{2,1,0,4,128,64},
    '{2,1,0,5,256,128}, '{2,1,0,6,512,256}, '{2,1,0,7,2048,1024}};

  always #12.5 core_clk = ~core_clk;

  t8w_top i_t8w_top (.core_clk(core_clk), .rst_n(rst_n), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .irq_ack_ovf(ack_o), .irq_ack_cmp(ack_c), .overflow_flag(ovf),
    .compare_match_flag(cmpf), .wave_pin_o(pin_o), .wave_pin_oe(pin_oe));
  t8w_load i_t8w_load (.pin_o(pin_o), .pin_oe(pin_oe), .level(lvl));

  // Closing report; every path that ends the run comes through here.
  task automatic print_verdict;
    $display("errors %0d, checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic hang;
    num_errors++;
    $display("CHECK FAILED at %0t: bus answer never came", $time);
    print_verdict();
  endtask

  // Beats go out together and drop when taken; bready stays high between writes.
  task automatic bus_wr(input [7:0] a, input [31:0] d, input [1:0] er);
    int n;
    awa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (awv && awr) awv <= 0;
      if (wv && wrdy) wv <= 0;
      if (bv) break;
    end
    if (n == 50) hang();
    chk(32'(bresp), 32'(er));
  endtask

  task automatic bus_rd(input [7:0] a, input [31:0] m, input [31:0] exp, input [1:0] er);
    int n;
    ara <= a; arv <= 1; rr <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (arv && arr) arv <= 0;
      if (rv) break;
    end
    if (n == 50) hang();
    chk(rdata & m, exp);
    chk(32'(rresp), 32'(er));
  endtask

  // Period and high time between two rises; with no rise, the high count of the wait.
  task automatic meas(output int p, output int h);
    int   n;
    logic q;
    q = lvl; h = 0; p = 0;
    for (n = 0; n < 2500; n++) begin
      @(posedge core_clk);
      if (lvl && !q) break;
      h += int'(lvl);
      q = lvl;
    end
    if (n == 2500) return;
    h = 0;
    for (p = 1; p < 2500; p++) begin
      h += int'(lvl);
      q = lvl;
      @(posedge core_clk);
      if (lvl && !q) break;
    end
  endtask

  // Compare is loaded while stopped in normal mode, so buffering cannot delay it.
  task automatic cfg(input [1:0] m, input [1:0] a, input [7:0] c, input [2:0] s);
    bus_wr(`T8W_OFF_CTRL, 0, 0);
    bus_wr(`T8W_OFF_CMP, {24'h0, c}, 0);
    bus_wr(`T8W_OFF_COUNT, 0, 0);
    bus_wr(`T8W_OFF_CTRL, {25'h0, s, a, m}, 0);
    meas(per, hi);
  endtask

  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1;
    @(posedge core_clk);
    for (i = 0; i <= 20; i += 4) bus_rd(8'(i), 32'hffffffff, 0, i > 16 ? 2'h2 : 2'h0);
    bus_wr(8'h14, 1, `T8W_RESP_SLVERR);
    bus_wr(`T8W_OFF_PIN, 1, 0);
    // Each waveform mode and every clock select except stop, measured on the pin.
    for (i = 0; i < 21; i++) begin
      cfg(2'(tab[i][0]), 2'(tab[i][1]), 8'(tab[i][2]), 3'(tab[i][3]));
      meas(per, hi);
      chk(per, tab[i][4]);
      chk(hi, tab[i][5]);
      // Overflow returns within 600 clocks except with a low clear-on-compare top.
      bus_wr(`T8W_OFF_FLAGS, 3, 0);
      repeat (600) @(posedge core_clk);
      bus_rd(`T8W_OFF_FLAGS, 1, 32'(tab[i][0] != 2), 0);
    end
    // With the direction set to input the running wave must not reach the pin.
    bus_wr(`T8W_OFF_PIN, 0, 0);
    meas(per, hi);
    meas(per, hi);
    chk(hi, 0);
    chk(32'(pin_oe), 0);
    // A compare value below the count only matches after the count wraps.
    bus_wr(`T8W_OFF_CTRL, 0, 0);
    bus_wr(`T8W_OFF_COUNT, 200, 0);
    bus_wr(`T8W_OFF_CTRL, `T8W_WGM_CTC, 0);
    bus_wr(`T8W_OFF_CMP, 10, 0);
    bus_wr(`T8W_OFF_FLAGS, 3, 0);
    bus_wr(`T8W_OFF_CTRL, {`T8W_CS_DIV1, `T8W_COM_OFF, `T8W_WGM_CTC}, 0);
    repeat (30) @(posedge core_clk);
    bus_rd(`T8W_OFF_FLAGS, 3, 0, 0);
    repeat (60) @(posedge core_clk);
    bus_rd(`T8W_OFF_FLAGS, 3, 3, 0);
    // Stopped, so no new event can race the clears.
    bus_wr(`T8W_OFF_CTRL, 0, 0);
    bus_wr(`T8W_OFF_FLAGS, 2, 0);
    bus_rd(`T8W_OFF_FLAGS, 3, 1, 0);
    ack_o <= 1;
    @(posedge core_clk);
    ack_o <= 0;
    @(posedge core_clk);
    bus_rd(`T8W_OFF_FLAGS, 3, 0, 0);
    // A count write equal to the compare value hides the first match only.
    bus_wr(`T8W_OFF_CMP, 5, 0);
    bus_wr(`T8W_OFF_COUNT, 5, 0);
    bus_wr(`T8W_OFF_CTRL, {`T8W_CS_DIV1, `T8W_COM_OFF, `T8W_WGM_NORMAL}, 0);
    bus_rd(`T8W_OFF_FLAGS, 3, 0, 0);
    repeat (260) @(posedge core_clk);
    bus_wr(`T8W_OFF_CTRL, 0, 0);
    chk(32'({ovf, cmpf}), 3);
    // Interrupt entry clears the compare flag and leaves overflow alone.
    ack_c <= 1;
    @(posedge core_clk);
    ack_c <= 0;
    @(posedge core_clk);
    bus_rd(`T8W_OFF_FLAGS, 3, 1, 0);
    chk(32'({ovf, cmpf}), 2);
    print_verdict();
  end
endmodule

bind t8w_top t8w_props i_t8w_props (.core_clk, .rst_n, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_araddr, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp, .irq_ack_ovf, .irq_ack_cmp,
  .overflow_flag, .compare_match_flag, .wave_pin_oe);

// ---- src/t8w_consts.vh ----
// Constants for the 8-bit timer waveform block: offsets, fields, resets, modes.
`ifndef T8W_CONSTS_VH
`define T8W_CONSTS_VH
`define T8W_OFF_CTRL   8'h00
`define T8W_OFF_COUNT  8'h04
`define T8W_OFF_CMP    8'h08
`define T8W_OFF_FLAGS  8'h0c
`define T8W_OFF_PIN    8'h10
`define T8W_CTRL_WGM   1:0
`define T8W_CTRL_COM   3:2
`define T8W_CTRL_CS    6:4
`define T8W_FLG_OVF    0
`define T8W_FLG_CMP    1
`define T8W_FLG_WAVE   2
`define T8W_PIN_DIR    0
`define T8W_PIN_DATA   1
`define T8W_CTRL_RST   7'h00
`define T8W_COUNT_RST  8'h00
`define T8W_CMP_RST    8'h00
`define T8W_PIN_RST    2'h0
`define T8W_WGM_NORMAL 2'h0
`define T8W_WGM_PCPWM  2'h1
`define T8W_WGM_CTC    2'h2
`define T8W_WGM_FAST   2'h3
`define T8W_COM_OFF    2'h0
`define T8W_COM_TOG    2'h1
`define T8W_COM_CLR    2'h2
`define T8W_COM_SET    2'h3
`define T8W_MAX        8'hff
`define T8W_BOTTOM     8'h00
`define T8W_CS_STOP    3'h0
`define T8W_CS_DIV1    3'h1
`define T8W_CS_DIV8    3'h2
`define T8W_CS_DIV32   3'h3
`define T8W_CS_DIV64   3'h4
`define T8W_CS_DIV128  3'h5
`define T8W_CS_DIV256  3'h6
`define T8W_CS_DIV1024 3'h7
`define T8W_RESP_OKAY  2'h0
`define T8W_RESP_SLVERR 2'h2
`endif

// ---- src/t8w_pin.v ----
// Port pin driver with waveform override and data direction control.
`timescale 1ns/100ps
`include "t8w_consts.vh"
module t8w_pin (
  input  wire       core_clk,
  input  wire       rst_n,
  input  wire [1:0] action,
  input  wire       wave,
  input  wire       port_data,
  input  wire       dir_out,
  output reg        pin_o,
  output reg        pin_oe
);
  // Any nonzero action hands the pin to the waveform; direction stays with software.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      pin_o  <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      pin_o  <= (action != `T8W_COM_OFF) ? wave : port_data;
      pin_oe <= dir_out;
    end
  end
endmodule

// ---- src/t8w_prescaler.v ----
// Timer clock enable generator dividing the core clock by the selected factor.
`timescale 1ns/100ps
`include "t8w_consts.vh"
module t8w_prescaler (
  input  wire       core_clk,
  input  wire       rst_n,
  input  wire [2:0] clk_sel,
  output reg        tick
);
  reg [9:0] div_q;

  // Free-running divider; its low bits all high mark one tick per factor.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      div_q <= 10'h000;
    end else begin
      div_q <= div_q + 10'h001;
    end
  end

  // Factor select; stop yields no tick at all.
  always @* begin
    case (clk_sel)
      `T8W_CS_DIV1:    tick = 1'b1;
      `T8W_CS_DIV8:    tick = &div_q[2:0];
      `T8W_CS_DIV32:   tick = &div_q[4:0];
      `T8W_CS_DIV64:   tick = &div_q[5:0];
      `T8W_CS_DIV128:  tick = &div_q[6:0];
      `T8W_CS_DIV256:  tick = &div_q[7:0];
      `T8W_CS_DIV1024: tick = &div_q[9:0];
      default:         tick = 1'b0;
    endcase
  end
endmodule

// ---- src/t8w_top.v ----
// Top of the 8-bit timer waveform block with its AXI4-Lite register slave.
// Functional notes
// - Mode 2 clears the count after it equals the compare value.
// - Clear-on-compare raises the compare flag at every top match.
// - Clear-on-compare with action 1 toggles the wave output per match.
// - The pin shows the wave only when its direction is output.
// - Clear-on-compare sets overflow when the count wraps from maximum to zero.
// - Clear-on-compare period is two times factor times one plus compare.
// - Mode 3 counts up to maximum, then clears to bottom.
// - Fast PWM non-inverting clears on match, sets at bottom; inverting opposite.
// - PWM action two selects non-inverted, three inverted output.
// - Fast PWM sets overflow each time the count reaches maximum.
// - Fast PWM period is 256 timer clocks.
// - Prescale factors 1, 8, 32, 64, 128, 256 and 1024 are offered.
// - Fast PWM: compare at bottom gives spikes, at maximum a constant level.
// - Fast PWM action 1 toggles on match with buffered compare value.
// - Mode 1 counts up and down, holding maximum for one timer clock.
// - Phase-correct clears on up match, sets on down match; inverting opposite.
// - Phase-correct sets overflow each time the count reaches bottom.
// - Phase-correct period is 510 timer clocks.
// - Phase-correct compare at bottom gives steady low, at maximum steady high.
// - At maximum, phase-correct output takes the up-match level unless compare is maximum.
// - Compare is buffered in PWM modes, direct in normal and clear-on-compare.
// - Compare flag sets a timer clock after equality; write one or ack clears.
// - A count write blocks a compare match in the next timer clock.
// - Mode 0 counts up, wraps, sets overflow as the count becomes zero.
`timescale 1ns/100ps
`include "t8w_consts.vh"
module t8w_top (
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  input  wire [7:0]  s_axi_araddr,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  input  wire        irq_ack_ovf,
  input  wire        irq_ack_cmp,
  output wire        overflow_flag,
  output wire        compare_match_flag,
  output wire        wave_pin_o,
  output wire        wave_pin_oe
);
  // Register state.
  reg  [6:0] ctrl_q;
  reg  [7:0] timer_count_q;
  reg  [7:0] compare_value_q;
  reg  [7:0] cmp_buf_q;
  reg        ovf_q;
  reg        cmp_flag_q;
  reg        wave_output_q;
  reg  [1:0] pin_q;
  reg        count_up_q;
  reg        block_q;
  // Bus holding state.
  reg        aw_held_q;
  reg  [7:0] awaddr_q;
  reg        w_held_q;
  reg  [7:0] wdata_q;
  reg        wstrb_q;

  wire       tick;
  wire [1:0] waveform_mode_select;
  wire [1:0] compare_output_action;
  wire       wr_fire;
  wire       wr_en;
  wire       wr_ctrl;
  wire       wr_count;
  wire       wr_cmp;
  wire       wr_flags;
  wire       wr_pin;
  wire       pwm_mode;
  wire       match;
  wire       at_max;
  wire       at_bottom;

  reg  [7:0] cnt_d;
  reg        up_d;
  reg        ovf_set;
  reg        wave_d;
  reg        load_buf;

  assign waveform_mode_select  = ctrl_q[`T8W_CTRL_WGM];
  assign compare_output_action = ctrl_q[`T8W_CTRL_COM];
  assign overflow_flag         = ovf_q;
  assign compare_match_flag    = cmp_flag_q;

  // True when the byte offset names a mapped register.
  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `T8W_OFF_CTRL) || (a == `T8W_OFF_COUNT) ||
               (a == `T8W_OFF_CMP) || (a == `T8W_OFF_FLAGS) ||
               (a == `T8W_OFF_PIN);
    end
  endfunction

  // Level that a PWM output action gives for a given non-inverted level.
  function pwm_level;
    input [1:0] act;
    input       noninv;
    begin
      pwm_level = (act == `T8W_COM_SET) ? ~noninv : noninv;
    end
  endfunction

  t8w_prescaler u_presc (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_sel  (ctrl_q[`T8W_CTRL_CS]),
    .tick     (tick)
  );

  t8w_pin u_pin (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .action    (compare_output_action),
    .wave      (wave_output_q),
    .port_data (pin_q[`T8W_PIN_DATA]),
    .dir_out   (pin_q[`T8W_PIN_DIR]),
    .pin_o     (wave_pin_o),
    .pin_oe    (wave_pin_oe)
  );

  // Write channels are taken independently; holding both makes one write.
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire       = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_en         = wr_fire && wstrb_q;
  assign wr_ctrl       = wr_en && (awaddr_q == `T8W_OFF_CTRL);
  assign wr_count      = wr_en && (awaddr_q == `T8W_OFF_COUNT);
  assign wr_cmp        = wr_en && (awaddr_q == `T8W_OFF_CMP);
  assign wr_flags      = wr_en && (awaddr_q == `T8W_OFF_FLAGS);
  assign wr_pin        = wr_en && (awaddr_q == `T8W_OFF_PIN);

  // Write address and data capture plus the response.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      aw_held_q    <= 1'b0;
      awaddr_q     <= 8'h00;
      w_held_q     <= 1'b0;
      wdata_q      <= 8'h00;
      wstrb_q      <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `T8W_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata[7:0];
        wstrb_q  <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awaddr_q) ? `T8W_RESP_OKAY : `T8W_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read answer one cycle after the address is taken; unmapped gives SLVERR.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `T8W_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mapped({s_axi_araddr[7:2], 2'b00}) ?
                      `T8W_RESP_OKAY : `T8W_RESP_SLVERR;
      case ({s_axi_araddr[7:2], 2'b00})
        `T8W_OFF_CTRL:  s_axi_rdata <= {25'h0, ctrl_q};
        `T8W_OFF_COUNT: s_axi_rdata <= {24'h0, timer_count_q};
        `T8W_OFF_CMP:   s_axi_rdata <= {24'h0, pwm_mode ? cmp_buf_q : compare_value_q};
        `T8W_OFF_FLAGS: s_axi_rdata <= {29'h0, wave_output_q, cmp_flag_q, ovf_q};
        `T8W_OFF_PIN:   s_axi_rdata <= {30'h0, pin_q};
        default:        s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign pwm_mode  = (waveform_mode_select == `T8W_WGM_PCPWM) ||
                     (waveform_mode_select == `T8W_WGM_FAST);
  assign at_max    = (timer_count_q == `T8W_MAX);
  assign at_bottom = (timer_count_q == `T8W_BOTTOM);
  // A count write blanks the comparator for the following timer clock.
  assign match     = (timer_count_q == compare_value_q) && !block_q;

  // Counter sequence, overflow condition and waveform action per mode.
  always @* begin
    cnt_d    = timer_count_q + 8'h01;
    up_d     = 1'b1;
    ovf_set  = 1'b0;
    wave_d   = wave_output_q;
    load_buf = 1'b0;
    case (waveform_mode_select)
      `T8W_WGM_NORMAL: begin
        ovf_set = at_max;
        if (match) begin
          case (compare_output_action)
            `T8W_COM_TOG: wave_d = ~wave_output_q;
            `T8W_COM_CLR: wave_d = 1'b0;
            `T8W_COM_SET: wave_d = 1'b1;
            default:      wave_d = wave_output_q;
          endcase
        end
      end
      `T8W_WGM_CTC: begin
        // No buffer: a top below the count is only met after the wrap.
        if (timer_count_q == compare_value_q) begin
          cnt_d = `T8W_BOTTOM;
        end
        ovf_set = at_max;
        if (match) begin
          case (compare_output_action)
            `T8W_COM_TOG: wave_d = ~wave_output_q;
            `T8W_COM_CLR: wave_d = 1'b0;
            `T8W_COM_SET: wave_d = 1'b1;
            default:      wave_d = wave_output_q;
          endcase
        end
      end
      `T8W_WGM_FAST: begin
        // Natural wrap after maximum gives the 256-clock single slope.
        ovf_set  = at_max;
        load_buf = at_max;
        if (compare_output_action == `T8W_COM_TOG) begin
          if (match) begin
            wave_d = ~wave_output_q;
          end
        end else if (compare_output_action != `T8W_COM_OFF) begin
          // Bottom wins over a match at maximum, giving the steady level.
          if (at_max) begin
            wave_d = pwm_level(compare_output_action, 1'b1);
          end else if (match) begin
            wave_d = pwm_level(compare_output_action, 1'b0);
          end
        end
      end
      default: begin
        // Dual slope: turn at maximum and bottom, 510 clocks per period.
        if (at_max) begin
          up_d  = 1'b0;
          cnt_d = timer_count_q - 8'h01;
        end else if (at_bottom) begin
          up_d  = 1'b1;
        end else begin
          up_d  = count_up_q;
          cnt_d = count_up_q ? timer_count_q + 8'h01 : timer_count_q - 8'h01;
        end
        ovf_set  = at_bottom && !count_up_q;
        load_buf = at_max;
        if (compare_output_action[1]) begin
          if (at_max) begin
            // Symmetry: maximum shows the up-match level unless compare is maximum.
            wave_d = pwm_level(compare_output_action,
                               compare_value_q == `T8W_MAX);
          end else if (match) begin
            // Bottom counts as the up slope so zero compare stays low.
            wave_d = pwm_level(compare_output_action,
                               !(count_up_q || at_bottom));
          end
        end
      end
    endcase
  end

  // Timer core: count, direction, compare buffer and waveform state.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      timer_count_q   <= `T8W_COUNT_RST;
      compare_value_q <= `T8W_CMP_RST;
      cmp_buf_q       <= `T8W_CMP_RST;
      wave_output_q   <= 1'b0;
      count_up_q      <= 1'b1;
      block_q         <= 1'b0;
    end else begin
      if (wr_count) begin
        timer_count_q <= wdata_q;
        block_q       <= 1'b1;
      end else if (tick) begin
        timer_count_q <= cnt_d;
        count_up_q    <= up_d;
        block_q       <= 1'b0;
      end
      if (tick) begin
        wave_output_q <= wave_d;
      end
      // Buffered in PWM modes; straight through otherwise.
      if (wr_cmp) begin
        cmp_buf_q <= wdata_q;
        if (!pwm_mode) begin
          compare_value_q <= wdata_q;
        end
      end
      if (!pwm_mode) begin
        cmp_buf_q <= wr_cmp ? wdata_q : compare_value_q;
      end else if (tick && load_buf) begin
        compare_value_q <= cmp_buf_q;
      end
    end
  end

  // Flags: hardware set wins over a software or acknowledge clear.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      ovf_q      <= 1'b0;
      cmp_flag_q <= 1'b0;
    end else begin
      if (tick && ovf_set) begin
        ovf_q <= 1'b1;
      end else if ((wr_flags && wdata_q[`T8W_FLG_OVF]) || irq_ack_ovf) begin
        ovf_q <= 1'b0;
      end
      if (tick && match) begin
        cmp_flag_q <= 1'b1;
      end else if ((wr_flags && wdata_q[`T8W_FLG_CMP]) || irq_ack_cmp) begin
        cmp_flag_q <= 1'b0;
      end
    end
  end

  // Control and pin registers.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_q <= `T8W_CTRL_RST;
      pin_q  <= `T8W_PIN_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wdata_q[6:0];
      end
      if (wr_pin) begin
        pin_q <= wdata_q[1:0];
      end
    end
  end
endmodule
